// >>> logic/sfsr_status_readback.v
// Serial fault status readback: latched faults, word select and serial output
`timescale 1ns/1ps
`default_nettype none
`include "sfsr_status_readback_map.vh"

module sfsr_status_readback #(
    parameter CHANNELS = 5,
    // Arbitrary identification value
    parameter [7:0] PART_CODE = `SFSR_PART_CODE_DEFAULT
) (
    input wire ref_clk,
    input wire rst,
    input wire spi_sclk,
    input wire spi_cs_n,
    input wire spi_mosi,
    output reg spi_miso,
    output reg spi_miso_oe,
    output reg [3:0] readback_address_select,
    output reg readback_address_persist,
    input wire fail_mode_indicator,
    input wire [CHANNELS-1:0] overtemp_shutdown_evt,
    input wire [CHANNELS-1:0] overtemp_warning_evt,
    input wire [CHANNELS-1:0] overcurrent_evt,
    input wire [3*CHANNELS-1:0] overcurrent_code_in,
    input wire [CHANNELS-1:0] open_load_on_state_evt,
    input wire [CHANNELS-1:0] open_load_off_state_evt,
    input wire undervoltage_in,
    input wire overvoltage_in,
    input wire charge_pump_fault_in,
    input wire clock_failure_in,
    input wire test_mode_active_in,
    input wire serial_link_fail_in,
    input wire registers_cleared_evt,
    input wire limp_input_level,
    input wire [3:0] control_input_level,
    input wire [3:0] input_toggle,
    input wire [CHANNELS-1:0] output_level_state
);

// ==========================================
// Pin synchronisers
reg sclk_s1_r, sclk_s2_r, sclk_s3_r;
reg cs_s1_r, cs_s2_r, cs_s3_r;
reg mosi_s1_r, mosi_s2_r;

always @(posedge ref_clk) begin
    if (rst) begin
        sclk_s1_r <= 1'b0;
        sclk_s2_r <= 1'b0;
        sclk_s3_r <= 1'b0;
        cs_s1_r <= 1'b1;
        cs_s2_r <= 1'b1;
        cs_s3_r <= 1'b1;
        mosi_s1_r <= 1'b0;
        mosi_s2_r <= 1'b0;
    end else begin
        sclk_s1_r <= spi_sclk;
        sclk_s2_r <= sclk_s1_r;
        sclk_s3_r <= sclk_s2_r;
        cs_s1_r <= spi_cs_n;
        cs_s2_r <= cs_s1_r;
        cs_s3_r <= cs_s2_r;
        mosi_s1_r <= spi_mosi;
        mosi_s2_r <= mosi_s1_r;
    end
end

// Third stages serve only the edge detectors
wire frame_start = cs_s3_r & ~cs_s2_r;
wire frame_end = ~cs_s3_r & cs_s2_r;
wire sclk_rise = ~cs_s2_r & ~sclk_s3_r & sclk_s2_r;
wire sclk_fall = ~cs_s2_r & sclk_s3_r & ~sclk_s2_r;

// ==========================================
// Latched fault flags
reg [CHANNELS-1:0] ots_r, otw_r, olon_r, oloff_r;
reg [3*CHANNELS-1:0] oc_r;
reg uvf_r, ovf_r, cpf_r, clock_failure_flag_r, tmf_r, serial_link_fail_flag_r, rcf_r;

// Channel code extraction
function [2:0] oc_of;
    input [3*CHANNELS-1:0] codes;
    input integer ch;
    begin
        oc_of = codes[3*ch +: 3];
    end
endfunction

// ==========================================
// Summary flags
reg [CHANNELS-1:0] quick_flag;
reg overload_summary_flag;
wire device_summary_flag = rcf_r | uvf_r | ovf_r | cpf_r | clock_failure_flag_r | tmf_r;
wire open_load_summary_flag = |(olon_r | oloff_r);
integer qi;

always @* begin
    overload_summary_flag = |ots_r;
    for (qi = 0; qi < CHANNELS; qi = qi + 1) begin
        quick_flag[qi] = (|oc_of(oc_r, qi)) | otw_r[qi] | ots_r[qi] | olon_r[qi] | oloff_r[qi];
        overload_summary_flag = overload_summary_flag | (|oc_of(oc_r, qi));
    end
end

wire [3:0] global_bits = {fail_mode_indicator, device_summary_flag, overload_summary_flag,
    open_load_summary_flag};

// ==========================================
// Fixed-layout words
reg [15:0] quick_word;
reg [15:0] dev_word;
reg [15:0] live_word;
reg [15:0] ident_word;

always @* begin
    quick_word = 16'h0000;
    quick_word[15:12] = `SFSR_CODE_QUICK;
    quick_word[11:8] = global_bits;
    quick_word[7] = cpf_r;
    quick_word[6] = rcf_r;
    quick_word[5] = clock_failure_flag_r;
    quick_word[4:0] = quick_flag;
    dev_word = 16'h0000;
    dev_word[15:12] = `SFSR_CODE_DEVICE;
    dev_word[11:8] = global_bits;
    dev_word[4] = tmf_r;
    dev_word[3] = ovf_r;
    dev_word[2] = uvf_r;
    dev_word[1] = serial_link_fail_flag_r;
    dev_word[0] = limp_input_level;
    // Live pins, no latch in the path
    live_word = 16'h0000;
    live_word[15:12] = `SFSR_CODE_LIVE;
    live_word[11] = fail_mode_indicator;
    live_word[9] = |input_toggle;
    live_word[8:5] = control_input_level;
    live_word[4:0] = output_level_state & {CHANNELS{~undervoltage_in}};
    // Part code hidden while the undervoltage flag is latched
    ident_word = 16'h0000;
    ident_word[15:12] = `SFSR_CODE_IDENT;
    ident_word[11] = fail_mode_indicator;
    ident_word[7:0] = uvf_r ? 8'h00 : PART_CODE;
end

// ==========================================
// Word assembly
reg [15:0] word_sel;
integer wch;

always @* begin
    wch = 0;
    case (readback_address_select)
    4'h2, 4'h3, 4'h4, 4'h5, 4'h6: begin
        wch = readback_address_select - 2;
        word_sel = {readback_address_select, global_bits, 1'b0, ots_r[wch], otw_r[wch],
            oc_of(oc_r, wch), olon_r[wch], oloff_r[wch]};
    end
    4'h7: begin
        word_sel = dev_word;
    end
    4'h8: begin
        word_sel = live_word;
    end
    4'h9: begin
        word_sel = ident_word;
    end
    default: begin
        word_sel = quick_word;
    end
    endcase
end

// ==========================================
// Serial frame engine
reg [15:0] tx_r;
reg [15:0] rx_r;
reg [4:0] bit_cnt_r;
reg [3:0] loaded_sel_r;
// Frozen at frame start so mid-frame events survive the clear
reg [15:0] snap_r;
reg [2:0] snap_quick_r;

always @(posedge ref_clk) begin
    if (rst) begin
        tx_r <= 16'h0000;
        rx_r <= 16'h0000;
        bit_cnt_r <= 5'h00;
        loaded_sel_r <= `SFSR_ADDR_DEFAULT;
        snap_r <= 16'h0000;
        snap_quick_r <= 3'b000;
        spi_miso <= 1'b0;
        spi_miso_oe <= 1'b0;
    end else begin
        if (frame_start) begin
            tx_r <= {word_sel[14:0], 1'b0};
            spi_miso <= word_sel[15];
            spi_miso_oe <= 1'b1;
            loaded_sel_r <= readback_address_select;
            snap_r <= word_sel;
            snap_quick_r <= {cpf_r, rcf_r, clock_failure_flag_r};
            bit_cnt_r <= 5'h00;
        end else begin
            if (sclk_rise) begin
                rx_r <= {rx_r[14:0], mosi_s2_r};
                if (bit_cnt_r != 5'h1F) begin
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                end
            end
            if (sclk_fall) begin
                spi_miso <= tx_r[15];
                tx_r <= {tx_r[14:0], 1'b0};
            end
            if (frame_end) begin
                spi_miso_oe <= 1'b0;
            end
        end
    end
end

// Only a frame of exactly sixteen bits may write or clear
wire frame_good = frame_end & (bit_cnt_r == `SFSR_FRAME_BITS);
wire frame_bad = frame_end & (bit_cnt_r != `SFSR_FRAME_BITS);
wire init1_write = frame_good & (rx_r[`SFSR_SI_ADDR_HI:`SFSR_SI_ADDR_LO] == `SFSR_SI_INIT1_ADDR);

// ==========================================
// Readback address control
always @(posedge ref_clk) begin
    if (rst) begin
        readback_address_select <= `SFSR_ADDR_DEFAULT;
        readback_address_persist <= 1'b0;
    end else if (init1_write) begin
        readback_address_select <= rx_r[`SFSR_SI_SEL_HI:`SFSR_SI_SEL_LO];
        readback_address_persist <= rx_r[`SFSR_SI_PERSIST_BIT];
    end else if (frame_good & ~readback_address_persist) begin
        readback_address_select <= `SFSR_ADDR_DEFAULT;
    end
end
// Persist keeps the address: only reset or an INIT1 write changes it

// ==========================================
// Read-to-clear decode
reg [CHANNELS-1:0] ch_clr;
wire dev_clr = frame_good & (loaded_sel_r == `SFSR_CODE_DEVICE);
integer ci;

always @* begin
    for (ci = 0; ci < CHANNELS; ci = ci + 1) begin
        ch_clr[ci] = frame_good & (loaded_sel_r == `SFSR_CODE_CH1 + ci);
    end
end

// ==========================================
// Clear masks: flags that left in the shifted word, quick-only flags as snapped at frame start
reg [CHANNELS-1:0] ots_clr, otw_clr, olon_clr, oloff_clr, oc_clr;
reg uvf_clr, ovf_clr, tmf_clr, serial_link_fail_flag_clr, cpf_clr, rcf_clr, clock_failure_flag_clr;
integer mi;

always @* begin
    ots_clr = {CHANNELS{1'b0}};
    otw_clr = {CHANNELS{1'b0}};
    olon_clr = {CHANNELS{1'b0}};
    oloff_clr = {CHANNELS{1'b0}};
    oc_clr = {CHANNELS{1'b0}};
    for (mi = 0; mi < CHANNELS; mi = mi + 1) begin
        ots_clr[mi] = ch_clr[mi] & snap_r[6];
        otw_clr[mi] = ch_clr[mi] & snap_r[5];
        oc_clr[mi] = ch_clr[mi] & (oc_of(oc_r, mi) == snap_r[4:2]);
        olon_clr[mi] = ch_clr[mi] & snap_r[1];
        oloff_clr[mi] = ch_clr[mi] & snap_r[0];
    end
    uvf_clr = dev_clr & snap_r[2];
    ovf_clr = dev_clr & snap_r[3];
    tmf_clr = dev_clr & snap_r[4];
    serial_link_fail_flag_clr = dev_clr & snap_r[1];
    cpf_clr = dev_clr & snap_quick_r[2];
    rcf_clr = dev_clr & snap_quick_r[1];
    clock_failure_flag_clr = dev_clr & snap_quick_r[0];
end

// ==========================================
// Channel flag latches, set wins over clear
reg [CHANNELS-1:0] ots_nxt, otw_nxt, olon_nxt, oloff_nxt;
reg [3*CHANNELS-1:0] oc_nxt;
integer ni;

always @* begin
    ots_nxt = (ots_r & ~ots_clr) | overtemp_shutdown_evt;
    otw_nxt = (otw_r & ~otw_clr) | overtemp_warning_evt;
    olon_nxt = (olon_r & ~olon_clr) | open_load_on_state_evt;
    oloff_nxt = (oloff_r & ~oloff_clr) | open_load_off_state_evt;
    oc_nxt = oc_r;
    for (ni = 0; ni < CHANNELS; ni = ni + 1) begin
        if (overcurrent_evt[ni]) begin
            oc_nxt[3*ni +: 3] = oc_of(overcurrent_code_in, ni);
        end else if (oc_clr[ni]) begin
            oc_nxt[3*ni +: 3] = `SFSR_OC_NONE;
        end
    end
end

always @(posedge ref_clk) begin
    if (rst) begin
        ots_r <= {CHANNELS{1'b0}};
        otw_r <= {CHANNELS{1'b0}};
        olon_r <= {CHANNELS{1'b0}};
        oloff_r <= {CHANNELS{1'b0}};
        oc_r <= {3*CHANNELS{1'b0}};
    end else begin
        ots_r <= ots_nxt;
        otw_r <= otw_nxt;
        olon_r <= olon_nxt;
        oloff_r <= oloff_nxt;
        oc_r <= oc_nxt;
    end
end

// ==========================================
// Device flag latches, set wins over clear
always @(posedge ref_clk) begin
    if (rst) begin
        uvf_r <= 1'b0;
        ovf_r <= 1'b0;
        cpf_r <= 1'b0;
        clock_failure_flag_r <= 1'b0;
        tmf_r <= 1'b0;
        serial_link_fail_flag_r <= 1'b0;
        rcf_r <= `SFSR_RCF_RESET;
    end else begin
        uvf_r <= (uvf_r & ~uvf_clr) | undervoltage_in;
        ovf_r <= (ovf_r & ~ovf_clr) | overvoltage_in;
        // Quick-only flags clear with the device word as well
        cpf_r <= (cpf_r & ~cpf_clr) | charge_pump_fault_in;
        clock_failure_flag_r <= (clock_failure_flag_r & ~clock_failure_flag_clr) | clock_failure_in;
        tmf_r <= (tmf_r & ~tmf_clr) | test_mode_active_in;
        serial_link_fail_flag_r <= (serial_link_fail_flag_r & ~serial_link_fail_flag_clr) | serial_link_fail_in | frame_bad;
        rcf_r <= (rcf_r & ~rcf_clr) | registers_cleared_evt;
    end
end

endmodule

`default_nettype wire

// >>> logic/sfsr_status_readback_map.vh
// Constants for the serial fault status readback block
// Behaviour
// - The readback word is chosen by the four-bit address select field.
// - Persist bit clear: programmed address serves one read, then quick word.
// - Persist bit set: programmed address serves every read until reprogrammed.
// - Each word carries its code in bits 15:12; address zero returns quick word.
// - Bit 11 of every word shows fail mode as one, normal as zero.
// - Summary flags in bits 10:8 clear only after all underlying faults are read.
// - Device summary is OR of cleared, undervolt, overvolt, pump, clock, test flags.
// - Overload summary is OR of all overcurrent and overtemperature shutdown indications.
// - Registers-cleared flag is set when serial registers return to reset state.
// - Channel quick flag is OR of code, overtemperature and open-load bits.
// - Channel word: shutdown 6, warning 5, code 4:2, open-load on 1, off 0.
// - Overcurrent code: none, inrush one to three, low, disable, severe short.
// - A newer overcurrent overwrites an unread code on that channel.
// - Device word: test 4, overvolt 3, undervolt 2, link fail 1, limp 0.
// - Limp bit reports the deglitched limp level live, never latched.
// - Pin word: toggle OR in 9, inputs 8:5, outputs 4:0, all live.
// - Output state bits are valid only while no undervoltage is present.
// - Identification bits return the part code, zeros while the undervoltage flag is latched.
// - Reading a channel word releases its latched open-load diagnosis.
`ifndef SFSR_STATUS_READBACK_MAP_VH
`define SFSR_STATUS_READBACK_MAP_VH

// ==========================================
// Word codes and readback addresses
`define SFSR_CODE_QUICK 4'h1
`define SFSR_CODE_CH1 4'h2
`define SFSR_CODE_CH5 4'h6
`define SFSR_CODE_DEVICE 4'h7
`define SFSR_CODE_LIVE 4'h8
`define SFSR_CODE_IDENT 4'h9
`define SFSR_ADDR_DEFAULT 4'h0

// ==========================================
// Received word layout
`define SFSR_SI_ADDR_HI 15
`define SFSR_SI_ADDR_LO 12
`define SFSR_SI_INIT1_ADDR 4'h0
`define SFSR_SI_SEL_HI 3
`define SFSR_SI_SEL_LO 0
`define SFSR_SI_PERSIST_BIT 4

// ==========================================
// Overcurrent codes
`define SFSR_OC_NONE 3'h0
`define SFSR_OC_INRUSH1 3'h1
`define SFSR_OC_INRUSH2 3'h2
`define SFSR_OC_INRUSH3 3'h3
`define SFSR_OC_LOW 3'h4
`define SFSR_OC_DISABLE 3'h5
`define SFSR_OC_SEVERE 3'h6

// ==========================================
// Frame and reset values
`define SFSR_FRAME_BITS 5'h10
`define SFSR_RCF_RESET 1'b1
`define SFSR_PART_CODE_DEFAULT 8'h5A

`endif

// >>> tb/sfsr_readback_chk.sv
// Port timing checker of the readback block
`timescale 1ns/1ps
`default_nettype none
module sfsr_readback_chk #(
    parameter CHANNELS = 5
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_miso,
    input wire logic spi_miso_oe,
    input wire logic [3:0] readback_address_select,
    input wire logic readback_address_persist
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // ==========================================
    // Assertions
    chk_reset_select: assert property ($fell(rst) |-> readback_address_select == 4'h0)
        else $error("Select not cleared by reset");
    chk_oe_rises: assert property ($fell(spi_cs_n) |-> ##[2:4] spi_miso_oe)
        else $error("Output enable late after select");
    chk_oe_falls: assert property ($rose(spi_cs_n) |-> ##[2:5] !spi_miso_oe)
        else $error("Output enable held after frame");
    chk_oe_idle: assert property (spi_cs_n [*6] |-> !spi_miso_oe)
        else $error("Output enabled outside frame");
    chk_select_steady: assert property ($changed(readback_address_select) |-> !spi_miso_oe)
        else $error("Select changed inside frame");
    chk_persist_steady: assert property ($changed(readback_address_persist) |-> !spi_miso_oe)
        else $error("Persist changed inside frame");
    chk_code_msb: assert property ($rose(spi_miso_oe) |-> spi_miso == (readback_address_select[3:1] == 3'b100))
        else $error("First bit does not match word code");
    chk_bit_hold: assert property (spi_miso_oe && $rose(spi_sclk) |-> $stable(spi_miso) [*3])
        else $error("Data bit moved near sampling edge");

    cov_frame: cover property ($rose(spi_miso_oe));
    cov_persist: cover property ($rose(readback_address_persist));
    cov_device: cover property (spi_miso_oe && readback_address_select == 4'h7);
endmodule

bind sfsr_status_readback sfsr_readback_chk #(.CHANNELS(CHANNELS)) sfsr_readback_chk_inst (
    .ref_clk(ref_clk),
    .rst(rst),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe),
    .readback_address_select(readback_address_select),
    .readback_address_persist(readback_address_persist)
);
`default_nettype wire

// >>> tb/sfsr_spi_master.sv
// Serial bus master model sending frames of nbits bits
`timescale 1ns/1ps
`default_nettype none
module sfsr_spi_master (
    input wire logic ref_clk,
    input wire logic spi_miso,
    output var logic spi_sclk,
    output var logic spi_cs_n,
    output var logic spi_mosi
);
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // ==========================================
    // One frame, MSB first, half period of 8 clocks
    task automatic xfer(input logic [15:0] si, input integer nbits, output logic [15:0] so);
        integer i;
        so = 16'h0000;
        @(negedge ref_clk) spi_cs_n = 1'b0;
        for (i = 15; i >= 16 - nbits; i--) begin
            spi_mosi = si[i];
            repeat (8) @(negedge ref_clk);
            so[i] = spi_miso;
            spi_sclk = 1'b1;
            repeat (8) @(negedge ref_clk);
            spi_sclk = 1'b0;
        end
        repeat (8) @(negedge ref_clk);
        spi_cs_n = 1'b1;
        // Released line shows inverse of last bit
        spi_mosi = ~spi_mosi;
        repeat (8) @(negedge ref_clk);
    endtask
endmodule
`default_nettype wire

// >>> tb/test_spi_fault_status_readback.sv
// Self-checking bench of the fault status readback block
`timescale 1ns/1ps
`default_nettype none
`include "sfsr_status_readback_map.vh"
module test_spi_fault_status_readback;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic fm = 1'b0;
    logic limp = 1'b0;
    logic [4:0] otw = 5'h00;
    logic [4:0] ots = 5'h00;
    logic [4:0] olon = 5'h00;
    logic rce = 1'b0;
    logic [15:0] junk;
    logic [4:0] oc_evt = 5'h00;
    logic [14:0] oc_code = 15'h0000;
    logic [4:0] ol_off = 5'h00;
    logic [5:0] dflag = 6'h00;
    logic [3:0] ctl = 4'h0;
    logic [3:0] tog = 4'h0;
    logic [4:0] outs = 5'h00;
    logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, persist;
    logic [3:0] sel;
    logic [15:0] dexp [6] = '{16'h7405, 16'h7409, 16'h7401, 16'h7401, 16'h7411, 16'h7003};
    integer fails = 0;
    integer comparisons = 0;
    integer cycles = 0;
    integer i;

    always #5 ref_clk = ~ref_clk;

    sfsr_status_readback sfsr_status_readback_inst (
        .ref_clk(ref_clk), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .readback_address_select(sel),
        .readback_address_persist(persist), .fail_mode_indicator(fm), .overtemp_shutdown_evt(ots),
        .overtemp_warning_evt(otw), .overcurrent_evt(oc_evt), .overcurrent_code_in(oc_code),
        .open_load_on_state_evt(olon), .open_load_off_state_evt(ol_off), .undervoltage_in(dflag[0]),
        .overvoltage_in(dflag[1]), .charge_pump_fault_in(dflag[2]), .clock_failure_in(dflag[3]),
        .test_mode_active_in(dflag[4]), .serial_link_fail_in(dflag[5]), .registers_cleared_evt(rce),
        .limp_input_level(limp), .control_input_level(ctl), .input_toggle(tog), .output_level_state(outs)
    );

    sfsr_spi_master sfsr_spi_master_inst (
        .ref_clk(ref_clk), .spi_miso(spi_miso), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi)
    );

    // ==========================================
    // Tasks
    task automatic give_verdict;
        if (fails == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic fr(input logic [15:0] si, input logic [15:0] exp);
        logic [15:0] so;
        sfsr_spi_master_inst.xfer(si, 16, so);
        cmp16("readback word", exp, so);
    endtask

    task automatic dpulse(input integer n);
        @(negedge ref_clk) dflag[n] = 1'b1;
        @(negedge ref_clk) dflag[n] = 1'b0;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            give_verdict();
        end
    end

    // ==========================================
    // Sequence
    initial begin
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        fr(16'h1000, 16'h1440);
        fr(16'h0007, 16'h1440);
        fr(16'h1000, 16'h7400);
        fr(16'h1000, 16'h1000);
        fm = 1'b1;
        oc_code[8:6] = `SFSR_OC_INRUSH2;
        oc_evt = 5'h04;
        otw = 5'h04;
        ol_off = 5'h01;
        @(negedge ref_clk) oc_code[8:6] = `SFSR_OC_SEVERE;
        @(negedge ref_clk) oc_evt = 5'h00;
        otw = 5'h00;
        ol_off = 5'h00;
        fr(16'h0014, 16'h1B05);
        fr(16'h1000, 16'h4B38);
        fr(16'h1000, 16'h4900);
        fr(16'h0012, 16'h4900);
        cmp16("address select", 16'h0012, {11'h000, persist, sel});
        fr(16'h1000, 16'h2901);
        fr(16'h1000, 16'h2800);
        ctl = 4'hA;
        tog = 4'h1;
        outs = 5'h15;
        fr(16'h0008, 16'h2800);
        fr(16'h1000, 16'h8B55);
        fm = 1'b0;
        fr(16'h0009, 16'h1000);
        fr(16'h1000, {8'h90, `SFSR_PART_CODE_DEFAULT});
        dpulse(0);
        fr(16'h0019, 16'h1400);
        fr(16'h1000, 16'h9000);
        fr(16'h0017, 16'h9000);
        limp = 1'b1;
        for (i = 0; i < 6; i++) begin
            dpulse(i);
            fr(16'h1000, dexp[i]);
        end
        fr(16'h1000, 16'h7001);
        ots = 5'h10;
        olon = 5'h02;
        rce = 1'b1;
        @(negedge ref_clk) ots = 5'h00;
        olon = 5'h00;
        rce = 1'b0;
        fr(16'h0010, 16'h7701);
        fr(16'h0013, 16'h1312);
        fr(16'h0016, 16'h3302);
        fr(16'h1000, 16'h6240);
        sfsr_spi_master_inst.xfer(16'h0000, 8, junk);
        fr(16'h0017, 16'h6000);
        fr(16'h1000, 16'h7003);
        rst = 1'b1;
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        fr(16'h1000, 16'h1440);
        cmp16("address select", 16'h0000, {11'h000, persist, sel});
        give_verdict();
    end
endmodule
`default_nettype wire
